// ### rtl/tec_timer.sv
// 8-bit timer/event counter channel with a classic Wishbone slave
`timescale 1ns/1ns
`default_nettype none
module tec_timer #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone classic slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic [31:0]            dat_o,
   output logic                   ack_o,
   // External count input and timer output
   input  wire logic              event_in_i,
   output logic                   timer_output_pin_o,
   // Match interrupt request, one-cycle pulse
   output logic                   match_irq_o
);
   import tec_pkg::*;

   tec_state_s st;
   tec_state_s next_st;
   logic       tick;
   logic       req;
   logic       wr;
   logic [7:0] wdat;
   logic [7:0] rsel;
   logic [7:0] adr8;
   logic       run;
   logic       pwm;
   logic       match;

   assign run = st.mode[MC_ENABLE];
   assign pwm = st.mode[MC_PWM];

   // Count clock source follows clock_select in every mode
   tec_tick_gen u_tick (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .run_i          (run),
      .clock_select_i (st.clksel),
      .event_in_i     (event_in_i),
      .tick_o         (tick)
   );

   always_comb begin
      next_st = st;
      adr8    = 8'(adr_i);
      req     = cyc_i & stb_i;
      // Write lands on the edge where the master sees ack high
      wr      = req & we_i & st.ack & sel_i[0];
      wdat    = dat_i[7:0];
      match   = (st.count == st.compare);
      rsel    = COUNT_ZERO;

      // Bus: one ack per request, dropped the cycle after
      next_st.ack = req & ~st.ack;
      case (adr8)
         OFS_COUNT:   rsel = st.count;
         OFS_COMPARE: rsel = st.compare;
         OFS_CLKSEL:  rsel = st.clksel;
         OFS_MODE:    rsel = st.mode;
         default:     rsel = COUNT_ZERO;
      endcase
      next_st.rdat = (req & ~st.ack) ? {24'h00_0000, rsel} : 32'h0000_0000;

      // Counter
      next_st.irq = 1'b0;
      if (!run) begin
         next_st.count   = COUNT_ZERO;
         next_st.pwm_act = 1'b0;
      end else if (tick) begin
         if (pwm) begin
            next_st.count = 8'(st.count + 8'h01);
            if (st.count == COUNT_MAX) begin
               // Zero compare gives zero width, never a glitch
               next_st.pwm_act = (st.compare != COUNT_ZERO);
            end else if (8'(st.count + 8'h01) == st.compare) begin
               next_st.pwm_act = 1'b0;
            end
            next_st.irq = match;
         end else if (match) begin
            next_st.count = COUNT_ZERO;
            next_st.irq   = 1'b1;
            if (st.mode[MC_INVPOL]) begin
               next_st.flop = ~st.flop;
            end
         end else begin
            next_st.count = 8'(st.count + 8'h01);
         end
      end

      // Register writes; the count register is read only
      if (wr) begin
         case (adr8)
            OFS_COMPARE: next_st.compare = wdat;
            OFS_CLKSEL:  next_st.clksel  = wdat;
            OFS_MODE: begin
               next_st.mode = wdat & MC_STORE_MASK;
               if (!wdat[MC_PWM]) begin
                  // Both strobes at once is a prohibited code: left unchanged
                  if (wdat[MC_SET] && !wdat[MC_RESET]) begin
                     next_st.flop = 1'b1;
                  end else if (!wdat[MC_SET] && wdat[MC_RESET]) begin
                     next_st.flop = 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // A stop written this cycle drops the PWM level at once, not one clock late
      if (!next_st.mode[MC_ENABLE]) begin
         next_st.pwm_act = 1'b0;
      end

      // Pin follows the settings whether or not the counter runs
      if (!next_st.mode[MC_OUTEN]) begin
         next_st.pin = 1'b0;
      end else if (next_st.mode[MC_PWM]) begin
         next_st.pin = next_st.pwm_act ^ next_st.mode[MC_INVPOL];
      end else begin
         next_st.pin = next_st.flop;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dat_o              = st.rdat;
   assign ack_o              = st.ack;
   assign timer_output_pin_o = st.pin;
   assign match_irq_o        = st.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_interval_match;
      run && !pwm && tick && match |=> (st.count == COUNT_ZERO) && st.irq;
   endproperty
   a_interval_match: assert property (p_interval_match)
      else $error("match did not clear counter and raise irq");

   property p_count_step;
      run && !pwm && tick && !match |=> st.count == 8'($past(st.count) + 8'h01) && !st.irq;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter did not advance by one on a tick");

   property p_irq_only_on_zero;
      st.irq && !pwm |-> st.count == COUNT_ZERO;
   endproperty
   a_irq_only_on_zero: assert property (p_irq_only_on_zero)
      else $error("irq without counter cleared");

   property p_stop_clears;
      !run |=> st.count == COUNT_ZERO;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("stopped counter not zero");

   property p_square_invert;
      run && !pwm && tick && match && st.mode[MC_INVPOL] && !wr |=> st.flop != $past(st.flop);
   endproperty
   a_square_invert: assert property (p_square_invert)
      else $error("flop did not invert on match");

   property p_outen_low;
      !st.mode[MC_OUTEN] |-> !timer_output_pin_o;
   endproperty
   a_outen_low: assert property (p_outen_low)
      else $error("pin not low with output disabled");

   property p_pwm_stop_inactive;
      pwm && !run && st.mode[MC_OUTEN] |-> timer_output_pin_o == st.mode[MC_INVPOL];
   endproperty
   a_pwm_stop_inactive: assert property (p_pwm_stop_inactive)
      else $error("stopped pwm output not inactive");

   property p_pwm_overflow;
      run && pwm && tick && st.count == COUNT_MAX && st.compare != COUNT_ZERO && !wr
         |=> st.pwm_act && st.count == COUNT_ZERO;
   endproperty
   a_pwm_overflow: assert property (p_pwm_overflow)
      else $error("pwm not active after overflow");

   property p_pwm_wrap;
      run && pwm && tick |=> st.count == 8'($past(st.count) + 8'h01);
   endproperty
   a_pwm_wrap: assert property (p_pwm_wrap)
      else $error("pwm counter did not run freely");

   property p_strobe_readzero;
      ack_o && !we_i && adr8 == OFS_MODE |-> dat_o[3:2] == 2'b00;
   endproperty
   a_strobe_readzero: assert property (p_strobe_readzero)
      else $error("set/reset bits read nonzero");

   property p_ack_once;
      ack_o |=> !ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack held longer than one cycle");

   property p_stopped_still;
      !run |=> !tick && !st.irq;
   endproperty
   a_stopped_still: assert property (p_stopped_still)
      else $error("count clock or irq while stopped");

   property p_count_hold;
      run && !tick |=> $stable(st.count);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("counter moved without a count clock");

   property p_irq_needs_tick;
      !tick |=> !st.irq;
   endproperty
   a_irq_needs_tick: assert property (p_irq_needs_tick)
      else $error("irq without a count clock");

   property p_rise_counts;
      run && st.clksel == CS_EXT_RISE && $rose(event_in_i) |=> tick;
   endproperty
   a_rise_counts: assert property (p_rise_counts)
      else $error("rising edge not counted");

   property p_rise_only;
      run && st.clksel == CS_EXT_RISE && !$rose(event_in_i) |=> !tick;
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("count clock without a rising edge");

   property p_fall_counts;
      run && st.clksel == CS_EXT_FALL && $fell(event_in_i) |=> tick;
   endproperty
   a_fall_counts: assert property (p_fall_counts)
      else $error("falling edge not counted");

   property p_pwm_drop;
      run && pwm && tick && st.count != COUNT_MAX && 8'(st.count + 8'h01) == st.compare
         && !wr |=> !st.pwm_act;
   endproperty
   a_pwm_drop: assert property (p_pwm_drop)
      else $error("pwm stayed active after match");

   property p_pwm_level;
      pwm && st.mode[MC_OUTEN] |-> timer_output_pin_o == (st.pwm_act ^ st.mode[MC_INVPOL]);
   endproperty
   a_pwm_level: assert property (p_pwm_level)
      else $error("pwm pin level does not follow polarity");

   property p_flop_on_pin;
      !pwm && st.mode[MC_OUTEN] |-> timer_output_pin_o == st.flop;
   endproperty
   a_flop_on_pin: assert property (p_flop_on_pin)
      else $error("pin does not show the output flop");

   property p_flop_set;
      wr && adr8 == OFS_MODE && !wdat[MC_PWM] && wdat[MC_SET] && !wdat[MC_RESET] |=> st.flop;
   endproperty
   a_flop_set: assert property (p_flop_set)
      else $error("set strobe did not set the flop");

   property p_flop_clear;
      wr && adr8 == OFS_MODE && !wdat[MC_PWM] && !wdat[MC_SET] && wdat[MC_RESET] |=> !st.flop;
   endproperty
   a_flop_clear: assert property (p_flop_clear)
      else $error("reset strobe did not clear the flop");

   property p_flop_pwm_keep;
      wr && adr8 == OFS_MODE && wdat[MC_PWM] && !(run && !pwm && tick && match)
         |=> $stable(st.flop);
   endproperty
   a_flop_pwm_keep: assert property (p_flop_pwm_keep)
      else $error("flop changed by a pwm mode write");

   c_interval_irq: cover property (run && !pwm && st.irq);
   c_square_toggle: cover property (run && !pwm && st.mode[MC_INVPOL] && $changed(st.flop));
   c_pwm_active: cover property (run && pwm && $rose(st.pwm_act));
   c_event_tick: cover property (run && st.clksel == CS_EXT_RISE && tick);
endmodule
`default_nettype wire

// ### rtl/tec_pkg.sv
// Shared constants and state types of the 8-bit timer/event counter
package tec_pkg;

   // Register byte offsets on the Wishbone bus
   localparam logic [7:0] OFS_COUNT   = 8'h00;
   localparam logic [7:0] OFS_COMPARE = 8'h04;
   localparam logic [7:0] OFS_CLKSEL  = 8'h08;
   localparam logic [7:0] OFS_MODE    = 8'h0C;

   // Reset values
   localparam logic [7:0] RST_COUNT   = 8'h00;
   localparam logic [7:0] RST_COMPARE = 8'h00;
   localparam logic [7:0] RST_CLKSEL  = 8'h00;
   localparam logic [7:0] RST_MODE    = 8'h00;

   // Field positions of mode_control
   localparam int MC_ENABLE  = 7;
   localparam int MC_PWM     = 6;
   localparam int MC_SET     = 3;
   localparam int MC_RESET   = 2;
   localparam int MC_INVPOL  = 1;
   localparam int MC_OUTEN   = 0;
   // Bits that are stored; set/reset strobes and bits 5..4 read as zero
   localparam logic [7:0] MC_STORE_MASK = 8'hC3;

   // clock_select encodings
   localparam logic [7:0] CS_EXT_FALL = 8'h00;
   localparam logic [7:0] CS_EXT_RISE = 8'h01;
   localparam logic [7:0] CS_INT_BASE = 8'h02;
   localparam logic [7:0] CS_DIV_MAX  = 8'h07;

   localparam logic [7:0] COUNT_MAX   = 8'hFF;
   localparam logic [7:0] COUNT_ZERO  = 8'h00;

   typedef struct packed {
      logic [7:0]  count;
      logic [7:0]  compare;
      logic [7:0]  clksel;
      logic [7:0]  mode;
      logic        flop;
      logic        pwm_act;
      logic        irq;
      logic        pin;
      logic        ack;
      logic [31:0] rdat;
   } tec_state_s;

   typedef struct packed {
      logic [7:0] pre;
      logic       ev_prev;
      logic       tick;
   } tec_tick_s;

endpackage

// ### rtl/tec_tick_gen.sv
// Count-clock generator: external edge detect or internal prescaler
`timescale 1ns/1ns
`default_nettype none
module tec_tick_gen (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // Control
   input  wire logic            run_i,
   input  wire logic [7:0]      clock_select_i,
   input  wire logic            event_in_i,
   // Count clock pulse
   output logic                 tick_o
);
   import tec_pkg::*;

   tec_tick_s st;
   tec_tick_s next_st;
   logic [7:0] div_exp;
   logic [7:0] div_mask;
   logic       ev_rise;
   logic       ev_fall;

   always_comb begin
      next_st = st;
      ev_rise = event_in_i & ~st.ev_prev;
      ev_fall = ~event_in_i & st.ev_prev;
      div_exp = 8'(clock_select_i - CS_INT_BASE);
      if (div_exp > CS_DIV_MAX) begin
         div_exp = CS_DIV_MAX;
      end
      div_mask = 8'((8'h01 << div_exp) - 8'h01);
      next_st.ev_prev = event_in_i;
      // Prescaler restarts with the counter, so the first count clock comes one cycle after the start
      next_st.pre = run_i ? 8'(st.pre + 8'h01) : COUNT_ZERO;
      if (!run_i) begin
         next_st.tick = 1'b0;
      end else if (clock_select_i == CS_EXT_FALL) begin
         next_st.tick = ev_fall;
      end else if (clock_select_i == CS_EXT_RISE) begin
         next_st.tick = ev_rise;
      end else begin
         next_st.tick = ((st.pre & div_mask) == COUNT_ZERO);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;
endmodule
`default_nettype wire

// ### tb/tec_ev_src.sv
// Partner model: external pulse source on the count input
`timescale 1ns/1ns
`default_nettype none
module tec_ev_src (
   // Clock and command
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       go_i,
   input  wire logic [7:0] toggles_i,
   // Pulse line and status
   output logic            event_o,
   output logic            busy_o
);
   logic [7:0] left;
   logic [1:0] sp;
   // Three clocks per level so every edge is seen by a clk-rate detector
   always @(posedge clk_i) begin
      if (rst_i) begin
         event_o <= 1'b0;
         busy_o  <= 1'b0;
         left    <= 8'h00;
         sp      <= 2'h0;
      end else if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         left   <= toggles_i;
         sp     <= 2'h0;
      end else if (busy_o) begin
         sp <= sp + 2'h1;
         if (sp == 2'h2) begin
            sp      <= 2'h0;
            event_o <= ~event_o;
            left    <= left - 8'h01;
            busy_o  <= (left != 8'h01);
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_tec_timer.sv
// Self-checking bench for the timer/event counter
`timescale 1ns/1ns
`default_nettype none
module tb_tec_timer;
   import tec_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, go, ack_o, ev, busy, pin, irq;
   logic [7:0]  adr, tog, rd;
   logic [3:0]  sel;
   logic [31:0] dat, dat_o;
   int          miscompares, check_count, hi, per, n0;
   int          nirq = 0;
   logic [7:0]  cs [4] = '{8'h02, 8'h02, 8'h03, 8'h09};
   logic [7:0]  nv [4] = '{8'h01, 8'hFF, 8'h03, 8'h01};

   tec_timer i_tec_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .event_in_i(ev), .timer_output_pin_o(pin), .match_irq_o(irq));
   tec_ev_src i_tec_ev_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .toggles_i(tog),
      .event_o(ev), .busy_o(busy));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (irq === 1'b1) nirq <= nirq + 1;

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Classic single cycle; waits for ack, a hang is caught by the watchdog
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("ack wait", n, 2);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'b1, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      chk($sformatf("reg %0h", a), rd, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   function automatic logic pb(input logic w);
      return w ? pin : irq;
   endfunction
   // High width and full period of the pin or the irq, from a rising edge
   task automatic span(input logic w);
      int k;
      k = 0;
      hi = 0;
      while (pb(w) !== 1'b0 && k < 2000) begin @(negedge clk_i); k++; end
      while (pb(w) !== 1'b1 && k < 2000) begin @(negedge clk_i); k++; end
      while (pb(w) === 1'b1 && k < 2000) begin @(negedge clk_i); hi++; k++; end
      per = hi;
      while (pb(w) === 1'b0 && k < 2000) begin @(negedge clk_i); per++; k++; end
      if (k >= 2000) chk("span", 0, 1);
   endtask
   task automatic pulses(input logic [7:0] n);
      int k;
      k = 0;
      @(posedge clk_i);
      go  <= 1'b1;
      tog <= n;
      @(posedge clk_i);
      go <= 1'b0;
      @(negedge clk_i);
      while (busy !== 1'b0 && k < 2000) begin @(negedge clk_i); k++; end
      idle(4);
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      final_report;
   end
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, go} = 4'h0;
      adr = 8'h00;
      tog = 8'h00;
      sel = 4'hF;
      dat = 32'h0000_0000;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(OFS_COUNT, RST_COUNT);
      rc(OFS_COMPARE, RST_COMPARE);
      rc(OFS_CLKSEL, RST_CLKSEL);
      rc(OFS_MODE, RST_MODE);
      wr(OFS_COUNT, 8'h55);
      wr(8'h10, 8'hAA);
      sel <= 4'h0;
      wr(OFS_COMPARE, 8'h77);
      sel <= 4'hF;
      rc(OFS_COUNT, 8'h00);
      rc(8'h10, 8'h00);
      rc(OFS_COMPARE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_MODE, 8'h00);
         wr(OFS_CLKSEL, cs[i]);
         wr(OFS_COMPARE, nv[i]);
         wr(OFS_MODE, 8'h80);
         span(1'b0);
         chk("irq width", hi, 1);
         chk("irq period", per, (nv[i] + 1) << (cs[i] - 2));
      end
      wr(OFS_MODE, 8'h00);
      rc(OFS_COUNT, 8'h00);
      n0 = nirq;
      idle(20);
      chk("stopped irq", nirq - n0, 0);
      wr(OFS_CLKSEL, CS_EXT_FALL);
      wr(OFS_COMPARE, 8'h04);
      wr(OFS_MODE, 8'h80);
      pulses(8'h09);
      rc(OFS_COUNT, 8'h04);
      chk("fall irq", nirq - n0, 0);
      wr(OFS_MODE, 8'h00);
      wr(OFS_CLKSEL, CS_EXT_RISE);
      wr(OFS_MODE, 8'h80);
      pulses(8'h0A);
      rc(OFS_COUNT, 8'h00);
      chk("rise irq", nirq - n0, 1);
      pulses(8'h04);
      rc(OFS_COUNT, 8'h02);
      wr(OFS_MODE, 8'h00);
      wr(OFS_CLKSEL, CS_INT_BASE);
      wr(OFS_COMPARE, 8'h02);
      wr(OFS_MODE, 8'h0B);
      idle(2);
      chk("pin set", pin, 1);
      rc(OFS_MODE, 8'h03);
      wr(OFS_MODE, 8'h07);
      idle(2);
      chk("pin reset", pin, 0);
      wr(OFS_MODE, 8'h83);
      span(1'b1);
      chk("square high", hi, 3);
      chk("square period", per, 6);
      wr(OFS_MODE, 8'h82);
      idle(2);
      chk("pin off", pin, 0);
      wr(OFS_MODE, 8'h00);
      wr(OFS_COMPARE, 8'h40);
      wr(OFS_MODE, 8'h41);
      wr(OFS_MODE, 8'hC1);
      idle(200);
      chk("pwm start", pin, 0);
      span(1'b1);
      chk("pwm width", hi, 8'h40);
      chk("pwm period", per, 256);
      wr(OFS_COMPARE, 8'hC0);
      span(1'b1);
      span(1'b1);
      chk("pwm new width", hi, 8'hC0);
      wr(OFS_MODE, 8'hC3);
      span(1'b1);
      span(1'b1);
      chk("pwm low active", hi, 256 - 8'hC0);
      wr(OFS_MODE, 8'h43);
      idle(3);
      chk("pwm stopped", pin, 1);
      wr(OFS_MODE, 8'h42);
      idle(3);
      chk("pwm disabled", pin, 0);
      final_report;
   end
endmodule
`default_nettype wire
